// ---- bench/peak_hold_result_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "phrc_cfg.svh"

module peak_hold_result_control_tb;
	import phrc_pkg::*;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
	logic wb_ack_o, conv_valid_i = 0, enh_cal_done_i = 0, supply_low_i = 0;
	phrc_word_t conv_ratio_i = 0, disp_data_o;
	logic auto_cal_o, enh_cal_start_o, filter_pd_o, modulator_pd_o, disp_drv_en_o, irq_o;
	int errors = 0, checks_done = 0, cycles = 0;

	phrc_top phrc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_valid_i(conv_valid_i),
		.conv_ratio_i(conv_ratio_i), .enh_cal_done_i(enh_cal_done_i), .supply_low_i(supply_low_i),
		.auto_cal_o(auto_cal_o), .enh_cal_start_o(enh_cal_start_o), .filter_pd_o(filter_pd_o),
		.modulator_pd_o(modulator_pd_o), .disp_drv_en_o(disp_drv_en_o), .disp_data_o(disp_data_o),
		.irq_o(irq_o));

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Whole run needs under two hundred cycles; the ceiling leaves ample slack
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			end_sim();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Request held until the edge that samples ack; read data taken there
	task automatic bus(input logic we, input logic [5:0] i, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= {i, 2'b00};
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		wb_we_i <= 0;
	endtask

	task automatic cv(input logic [15:0] r);
		@(posedge clk_i);
		conv_valid_i <= 1;
		conv_ratio_i <= r;
		@(posedge clk_i);
		conv_valid_i <= 0;
		cyc(3);
	endtask

	function automatic logic [19:0] cnt(input logic signed [15:0] r, input logic v45, input logic rg);
		int c;
		c = (r * (v45 ? 20480 : 2048)) >>> 15;
		if (rg) c = c * 10;
		if (r < 0) c = c + 1;
		return c[19:0];
	endfunction

	task automatic sc(input logic [31:0] ctl, input logic [15:0] r);
		logic [19:0] c;
		c = cnt(r, ctl[9], ctl[8]);
		bus(1, `PHRC_IDX_CTRL, ctl);
		cv(r);
		bus(0, `PHRC_IDX_RES, 0);
		chk("result", rd, {12'h000, c});
		chk("disp", disp_data_o, ctl[9] ? c[15:0] : {c[11:0], 4'h0});
	endtask

	task automatic t_reset;
		bus(0, `PHRC_IDX_PEAK, 0);
		chk("peak", rd, 32'h0000B1E0);
		bus(0, `PHRC_IDX_CTRL, 0);
		chk("ctrl", rd, 32'h00000240);
		chk("auto_cal", auto_cal_o, 1);
		chk("disp", disp_data_o, 0);
		$display("t_reset done");
	endtask

	task automatic t_scale;
		sc(32'h240, 16'hC000);
		sc(32'h340, 16'h0100);
		sc(32'h040, 16'h4000);
		sc(32'h140, 16'hFF00);
		sc(32'h240, 16'h4000);
		$display("t_scale done");
	endtask

	task automatic t_peak;
		bus(1, `PHRC_IDX_CTRL, 32'h241);
		bus(0, `PHRC_IDX_PEAK, 0);
		chk("peak load", rd, 32'h2800);
		cv(16'hC000);
		bus(0, `PHRC_IDX_PEAK, 0);
		chk("peak signed", rd, 32'h2800);
		chk("disp peak", disp_data_o, 16'h2800);
		cv(16'h6000);
		bus(0, `PHRC_IDX_PEAK, 0);
		chk("peak grow", rd, 32'h3C00);
		bus(1, `PHRC_IDX_CTRL, 32'h240);
		bus(0, `PHRC_IDX_PEAK, 0);
		chk("peak clear", rd, 0);
		$display("t_peak done");
	endtask

	task automatic t_hold;
		cv(16'h4000);
		bus(1, `PHRC_IDX_CTRL, 32'h242);
		cv(16'h2000);
		chk("disp hold", disp_data_o, 16'h2800);
		bus(0, `PHRC_IDX_RES, 0);
		chk("result hold", rd, 32'h1400);
		$display("t_hold done");
	endtask

	task automatic t_power;
		bus(1, `PHRC_IDX_CTRL, 32'h234);
		cyc(3);
		chk("pd", {auto_cal_o, filter_pd_o, modulator_pd_o, disp_drv_en_o}, 4'b0110);
		bus(1, `PHRC_IDX_CTRL, 32'h240);
		$display("t_power done");
	endtask

	task automatic t_cal_irq;
		int k;
		bus(1, `PHRC_IDX_IMASK, 32'h8);
		cyc(2);
		chk("irq masked", irq_o, 0);
		bus(1, `PHRC_IDX_CTRL, 32'h348);
		k = 0;
		while (enh_cal_start_o !== 1'b1 && k < 10) begin
			@(posedge clk_i);
			k++;
		end
		chk("cal start", enh_cal_start_o, 1);
		bus(0, `PHRC_IDX_STAT, 0);
		chk("cal busy", rd[1], 1);
		@(posedge clk_i);
		enh_cal_done_i <= 1;
		@(posedge clk_i);
		enh_cal_done_i <= 0;
		cyc(3);
		chk("irq set", irq_o, 1);
		bus(1, `PHRC_IDX_ISTAT, 32'h8);
		cyc(3);
		chk("irq clear", irq_o, 0);
		bus(1, `PHRC_IDX_CTRL, 32'h240);
		$display("t_cal_irq done");
	endtask

	task automatic t_misc;
		@(posedge clk_i);
		supply_low_i <= 1;
		cyc(6);
		bus(0, `PHRC_IDX_STAT, 0);
		chk("low flag", rd[0], 1);
		supply_low_i <= 0;
		bus(1, `PHRC_IDX_CTRL, 32'h2C0);
		bus(1, `PHRC_IDX_DISP, 32'h1234);
		cyc(3);
		chk("disp sw", disp_data_o, 16'h1234);
		bus(0, 6'h3F, 0);
		chk("unmapped", rd, 0);
		bus(0, `PHRC_IDX_STAT, 0);
		chk("low clear", rd[0], 0);
		$display("t_misc done");
	endtask

	initial begin
		cyc(5);
		rst_i <= 0;
		cyc(2);
		t_reset();
		t_scale();
		t_peak();
		t_hold();
		t_power();
		t_cal_irq();
		t_misc();
		rst_i <= 1;
		cyc(2);
		rst_i <= 0;
		cyc(2);
		t_reset();
		end_sim();
	end
endmodule

`default_nettype wire

// ---- core/phrc_cfg.svh ----
`ifndef PHRC_CFG_SVH
`define PHRC_CFG_SVH

// Word offsets on the register bus (byte address = index * 4)
`define PHRC_IDX_CTRL 6'h00
`define PHRC_IDX_STAT 6'h01
`define PHRC_IDX_RES 6'h02
`define PHRC_IDX_PEAK 6'h03
`define PHRC_IDX_DISP 6'h04
`define PHRC_IDX_ISTAT 6'h05
`define PHRC_IDX_IMASK 6'h06

// Control register fields
`define PHRC_C_PEAK 0
`define PHRC_C_HOLD 1
`define PHRC_C_AZCN 2
`define PHRC_C_ECAL 3
`define PHRC_C_FPD 4
`define PHRC_C_MPD 5
`define PHRC_C_DEN 6
`define PHRC_C_SRC 7
`define PHRC_C_RANGE 8
`define PHRC_C_V45 9
`define PHRC_CTRL_W 10
`define PHRC_CTRL_RST 10'h240

// Status register fields
`define PHRC_S_LOW 0
`define PHRC_S_BUSY 1

// Interrupt event bits
`define PHRC_I_RES 0
`define PHRC_I_PEAK 1
`define PHRC_I_LOW 2
`define PHRC_I_CAL 3
`define PHRC_IRQ_W 4

// Reset values
`define PHRC_PEAK_RST 16'hB1E0
`define PHRC_DISP_RST 16'h0000

// Scale factors: 1.024 times full scale
`define PHRC_K45 19'h05000
`define PHRC_K35 19'h00800

`endif

// ---- core/phrc_pkg.sv ----
`default_nettype none

package phrc_pkg;

	typedef logic [15:0] phrc_word_t;
	typedef logic signed [19:0] phrc_count_t;

	typedef enum logic [1:0] {
		PHRC_CAL_IDLE = 2'b00,
		PHRC_CAL_START = 2'b01,
		PHRC_CAL_BUSY = 2'b11
	} phrc_cal_e;

endpackage

`default_nettype wire

// ---- core/phrc_top.sv ----
// Notes on behaviour
// - Read-only 16-bit peak register, reset value B1E0 hex.
// - Setting peak tracking copies the current result into the peak register.
// - While tracking, a larger new result replaces the peak; otherwise kept.
// - Writing peak tracking to zero while it is set clears the peak register.
// - Peak is two's complement: 16 bits, or 12 bits plus four sub-bits.
// - Reset returns all logic and every register to defaults.
// - Offset calibration runs with each conversion while auto-cal bit is zero.
// - Writing 1 to enhanced-cal bit runs one enhanced calibration on demand.
// - Filter power-down bit powers down the digital filter, independently.
// - Modulator power-down bit powers down modulator and input buffers.
// - Display enable at zero powers down segment and digit drivers.
// - While tracking, the display shows only the highest value measured.
// - Hold keeps showing the reading current when hold was set.
// - Supply-low status flag is high while the comparator reports low input.
// - Result is 1.024 times ratio times full scale, two's complement.
// - Range bit multiplies count by ten; negative inputs add one count.
// - Display data comes from the result word or from bus writes.
`timescale 1ns/1ps
`default_nettype none
`include "phrc_cfg.svh"

module phrc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic conv_valid_i,
	input wire phrc_pkg::phrc_word_t conv_ratio_i,
	input wire logic enh_cal_done_i,
	input wire logic supply_low_i,
	output logic auto_cal_o,
	output logic enh_cal_start_o,
	output logic filter_pd_o,
	output logic modulator_pd_o,
	output logic disp_drv_en_o,
	output phrc_pkg::phrc_word_t disp_data_o,
	output logic irq_o
);
	import phrc_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic phrc_count_t scale(input phrc_word_t ratio, input logic v45,
		input logic range);
		logic signed [34:0] p;
		phrc_count_t c;
		p = $signed(ratio) * $signed(v45 ? `PHRC_K45 : `PHRC_K35);
		c = p[34:15];
		if (range) begin
			c = (c <<< 3) + (c <<< 1);
		end
		if (ratio[15]) begin
			c = c + 20'sh00001;
		end
		return c;
	endfunction

	// Short variant keeps 12 significant bits at the top, four zero sub-bits
	function automatic phrc_word_t pack(input phrc_count_t c, input logic v45);
		return v45 ? c[15:0] : {c[11:0], 4'h0};
	endfunction

	function automatic logic gt(input phrc_word_t a, input phrc_word_t b);
		return $signed(a) > $signed(b);
	endfunction

	logic [`PHRC_CTRL_W-1:0] ctrl;
	logic [`PHRC_IRQ_W-1:0] irq_stat;
	logic [`PHRC_IRQ_W-1:0] irq_mask;
	phrc_count_t result;
	phrc_word_t peak;
	phrc_word_t disp;
	phrc_cal_e cal_st;
	logic low_s1;
	logic low_s2;
	logic low_s3;
	logic low_flag;

	logic req;
	logic wr;
	logic [5:0] idx;
	logic [31:0] wdat;
	logic [31:0] rdata;
	logic wr_ctrl;
	logic [`PHRC_CTRL_W-1:0] next_ctrl;
	phrc_count_t next_count;
	phrc_word_t next_word;
	phrc_word_t cur_word;
	logic peak_on;
	logic peak_off;
	logic peak_grow;
	logic [`PHRC_IRQ_W-1:0] ev;

	assign req = wb_cyc_i & wb_stb_i;
	// Writes commit at the edge where the master sees ack
	assign wr = req & wb_we_i & wb_ack_o;
	assign idx = wb_adr_i[7:2];
	assign wdat = merge(rdata, wb_dat_i, wb_sel_i);
	assign wr_ctrl = wr & (idx == `PHRC_IDX_CTRL);
	assign next_ctrl = wdat[`PHRC_CTRL_W-1:0];

	assign next_count = scale(conv_ratio_i, ctrl[`PHRC_C_V45], ctrl[`PHRC_C_RANGE]);
	assign next_word = pack(next_count, ctrl[`PHRC_C_V45]);
	assign cur_word = pack(result, ctrl[`PHRC_C_V45]);

	assign peak_on = wr_ctrl & next_ctrl[`PHRC_C_PEAK] & ~ctrl[`PHRC_C_PEAK];
	assign peak_off = wr_ctrl & ~next_ctrl[`PHRC_C_PEAK] & ctrl[`PHRC_C_PEAK];
	assign peak_grow = ctrl[`PHRC_C_PEAK] & conv_valid_i & gt(next_word, peak);

	always_comb begin
		rdata = 32'h00000000;
		unique case (idx)
			`PHRC_IDX_CTRL: rdata[`PHRC_CTRL_W-1:0] = ctrl;
			`PHRC_IDX_STAT: begin
				rdata[`PHRC_S_LOW] = low_flag;
				rdata[`PHRC_S_BUSY] = (cal_st != PHRC_CAL_IDLE);
			end
			`PHRC_IDX_RES: rdata[19:0] = result;
			`PHRC_IDX_PEAK: rdata[15:0] = peak;
			`PHRC_IDX_DISP: rdata[15:0] = disp;
			`PHRC_IDX_ISTAT: rdata[`PHRC_IRQ_W-1:0] = irq_stat;
			`PHRC_IDX_IMASK: rdata[`PHRC_IRQ_W-1:0] = irq_mask;
			default: rdata = 32'h00000000;
		endcase
	end

	// Unmapped words are acked, read as zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req & ~wb_ack_o) begin
				wb_dat_o <= rdata;
			end
		end
	end

	// Enhanced-cal bit is a trigger and always reads back zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `PHRC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= next_ctrl & ~(`PHRC_CTRL_W'(1) << `PHRC_C_ECAL);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_cal_o <= 1'b0;
			filter_pd_o <= 1'b0;
			modulator_pd_o <= 1'b0;
			disp_drv_en_o <= 1'b0;
		end else begin
			auto_cal_o <= ~ctrl[`PHRC_C_AZCN];
			filter_pd_o <= ctrl[`PHRC_C_FPD];
			modulator_pd_o <= ctrl[`PHRC_C_MPD];
			disp_drv_en_o <= ctrl[`PHRC_C_DEN];
		end
	end

	// Result keeps updating even while hold freezes the display
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result <= 20'sh00000;
		end else if (conv_valid_i) begin
			result <= next_count;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peak <= `PHRC_PEAK_RST;
		end else if (peak_off) begin
			peak <= 16'h0000;
		end else if (peak_on) begin
			peak <= cur_word;
		end else if (peak_grow) begin
			peak <= next_word;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			disp <= `PHRC_DISP_RST;
		end else if (ctrl[`PHRC_C_SRC]) begin
			if (wr & (idx == `PHRC_IDX_DISP)) begin
				disp <= wdat[15:0];
			end
		end else if (ctrl[`PHRC_C_HOLD]) begin
			disp <= disp;
		end else if (peak_on) begin
			disp <= cur_word;
		end else if (conv_valid_i) begin
			if (ctrl[`PHRC_C_PEAK]) begin
				disp <= peak_grow ? next_word : peak;
			end else begin
				disp <= next_word;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			disp_data_o <= `PHRC_DISP_RST;
		end else begin
			disp_data_o <= disp;
		end
	end

	// Start is a single pulse; a second request while busy is dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cal_st <= PHRC_CAL_IDLE;
			enh_cal_start_o <= 1'b0;
		end else begin
			enh_cal_start_o <= 1'b0;
			unique case (cal_st)
				PHRC_CAL_IDLE: begin
					if (wr_ctrl & next_ctrl[`PHRC_C_ECAL]) begin
						cal_st <= PHRC_CAL_START;
					end
				end
				PHRC_CAL_START: begin
					enh_cal_start_o <= 1'b1;
					cal_st <= PHRC_CAL_BUSY;
				end
				PHRC_CAL_BUSY: begin
					if (enh_cal_done_i) begin
						cal_st <= PHRC_CAL_IDLE;
					end
				end
				default: cal_st <= PHRC_CAL_IDLE;
			endcase
		end
	end

	// Comparator output is asynchronous; only the later two stages are compared
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_s1 <= 1'b0;
			low_s2 <= 1'b0;
			low_s3 <= 1'b0;
			low_flag <= 1'b0;
		end else begin
			low_s1 <= supply_low_i;
			low_s2 <= low_s1;
			low_s3 <= low_s2;
			if (low_s2 == low_s3) begin
				low_flag <= low_s3;
			end
		end
	end

	always_comb begin
		ev = '0;
		ev[`PHRC_I_RES] = conv_valid_i;
		ev[`PHRC_I_PEAK] = peak_grow & ~peak_on & ~peak_off;
		ev[`PHRC_I_LOW] = (low_s2 == low_s3) & low_s3 & ~low_flag;
		ev[`PHRC_I_CAL] = (cal_st == PHRC_CAL_BUSY) & enh_cal_done_i;
	end

	// A new event in the clearing cycle survives the write-one-to-clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
			irq_mask <= '0;
			irq_o <= 1'b0;
		end else begin
			if (wr & (idx == `PHRC_IDX_ISTAT)) begin
				// Raw lane data: the merged read-back would clear every set bit
				irq_stat <= (irq_stat & ~(wb_dat_i[`PHRC_IRQ_W-1:0] & {`PHRC_IRQ_W{wb_sel_i[0]}})) | ev;
			end else begin
				irq_stat <= irq_stat | ev;
			end
			if (wr & (idx == `PHRC_IDX_IMASK)) begin
				irq_mask <= wdat[`PHRC_IRQ_W-1:0];
			end
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_peak_reset_val:
	assert property ($past(rst_i) |-> peak == `PHRC_PEAK_RST)
		else $error("peak not at reset value after reset");

	a_peak_first_load:
	assert property (peak_on |=> peak == $past(cur_word))
		else $error("peak not loaded from current result");

	a_peak_never_drops:
	assert property (ctrl[`PHRC_C_PEAK] && !wr_ctrl |=> $signed(peak) >= $signed($past(peak)))
		else $error("peak decreased while tracking");

	a_peak_takes_max:
	assert property (ctrl[`PHRC_C_PEAK] && conv_valid_i && !wr_ctrl
		|=> $signed(peak) >= $signed($past(next_word)))
		else $error("larger result not captured as peak");

	a_peak_cleared:
	assert property (peak_off |=> peak == 16'h0000 ##1 peak == 16'h0000 || ctrl[`PHRC_C_PEAK])
		else $error("peak not cleared when tracking stopped");

	a_hold_freeze:
	assert property (ctrl[`PHRC_C_HOLD] && !ctrl[`PHRC_C_SRC] && !wr_ctrl
		|=> $stable(disp))
		else $error("display changed during hold");

	a_hold_result_runs:
	assert property (conv_valid_i |=> result == $past(next_count))
		else $error("result not updated by conversion");

	a_disp_shows_peak:
	assert property (ctrl[`PHRC_C_PEAK] && !ctrl[`PHRC_C_HOLD] && !ctrl[`PHRC_C_SRC]
		&& conv_valid_i && !wr_ctrl |=> disp == peak ##1 disp_data_o == $past(peak))
		else $error("display not showing peak while tracking");

	a_cal_one_pulse:
	assert property (cal_st == PHRC_CAL_IDLE && wr_ctrl && next_ctrl[`PHRC_C_ECAL]
		|=> !enh_cal_start_o ##1 enh_cal_start_o ##1 !enh_cal_start_o)
		else $error("enhanced calibration start not a single pulse");

	a_low_flag_follow:
	assert property ($rose(low_s3) && low_s2 |=> low_flag)
		else $error("supply-low flag did not follow comparator");

	a_pd_outputs:
	assert property (wr_ctrl |-> ##2 filter_pd_o == $past(next_ctrl[`PHRC_C_FPD], 2)
		&& modulator_pd_o == $past(next_ctrl[`PHRC_C_MPD], 2))
		else $error("power-down outputs do not track control");

	a_drv_enable:
	assert property (wr_ctrl && !next_ctrl[`PHRC_C_DEN] |-> ##2 !disp_drv_en_o)
		else $error("display drivers not powered down");

	a_wb_ack_once:
	assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");

endmodule

`default_nettype wire
